// File: inc/gtug_pkg.sv
package gtug_pkg;

  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 8;
  localparam int NUM_BANKS    = 4;
  localparam int GRP_PER_BANK = 4;
  localparam int NUM_GROUPS   = NUM_BANKS * GRP_PER_BANK;
  localparam int GRP_W        = 4;
  localparam int TX_ELEMS     = 8;
  localparam int RX_ELEMS     = 4;
  localparam int TX_IDX_W     = 3;
  localparam int RX_IDX_W     = 2;

  // guard registers, one per bank of four groups
  localparam logic [ADDR_W-1:0] GUARD_OFF [NUM_BANKS] = '{
    12'h41f, 12'h51f, 12'h61f, 12'h71f
  };

  // first element of the lowest group of each bank
  localparam logic [ADDR_W-1:0] TX_BASE [NUM_BANKS] = '{
    12'h420, 12'h520, 12'h620, 12'h720
  };
  localparam logic [ADDR_W-1:0] RX_BASE [NUM_BANKS] = '{
    12'h4d0, 12'h5d0, 12'h6d0, 12'h7d0
  };

  localparam logic [ADDR_W-1:0] TX_SPAN = 12'(GRP_PER_BANK * TX_ELEMS);
  localparam logic [ADDR_W-1:0] RX_SPAN = 12'(GRP_PER_BANK * RX_ELEMS);

  // guard register field positions
  localparam int TX_FIELD_LSB = 0;
  localparam int RX_FIELD_LSB = 4;

  localparam logic [DATA_W-1:0] GUARD_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE   = 8'h00;

  // variants: groups that exist in silicon
  localparam int IMPL_SMALL  = 2;
  localparam int IMPL_MEDIUM = 4;
  localparam int IMPL_LARGE  = 16;

endpackage

// File: logic/gtug_group_table_guard.sv
// Function
// - flag returns to zero once all table elements are written
// - flag reads one while updating, zero otherwise
// - first guard register bits 3..0 guard transmit groups 4..1 at 0x420
// - first guard register bits 7..4 guard receive groups 4..1 at 0x4d0
// - second guard register covers groups 5..8, tables at 0x520 and 0x5d0
// - third guard register covers groups 9..12, tables at 0x620 and 0x6d0
// - fourth guard register covers groups 13..16, tables at 0x720, 0x7d0
// - smallest variant has only groups 1 and 2
// - groups 5..16 exist only on the largest variant
`timescale 1ns/1ps
`default_nettype none

module gtug_group_table_guard
  import gtug_pkg::*;
#(
  parameter int NUM_IMPL = IMPL_LARGE
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [GRP_W-1:0]  eng_tx_grp,
  input  wire logic [2:0]        eng_tx_idx,
  output logic      [DATA_W-1:0] eng_tx_data,
  input  wire logic [GRP_W-1:0]  eng_rx_grp,
  input  wire logic [1:0]        eng_rx_idx,
  output logic      [DATA_W-1:0] eng_rx_data,
  output logic      [NUM_GROUPS-1:0] tx_updating,
  output logic      [NUM_GROUPS-1:0] rx_updating,
  output logic      [NUM_GROUPS-1:0] tx_commit,
  output logic      [NUM_GROUPS-1:0] rx_commit
);

  localparam int TX_DEPTH = NUM_GROUPS * TX_ELEMS;
  localparam int RX_DEPTH = NUM_GROUPS * RX_ELEMS;

  // decode result: {guard, tx, rx, group, element}
  localparam int DEC_W = 3 + GRP_W + TX_IDX_W;

  function automatic logic in_span(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base,
    input logic [ADDR_W-1:0] span
  );
    return (a >= base) && (a < base + span);
  endfunction

  // flat element index, shared by the bus side and the engine side
  function automatic logic [GRP_W+TX_IDX_W-1:0] tx_slot(
    input logic [GRP_W-1:0]    grp,
    input logic [TX_IDX_W-1:0] idx
  );
    return {grp, idx};
  endfunction

  function automatic logic [GRP_W+RX_IDX_W-1:0] rx_slot(
    input logic [GRP_W-1:0]    grp,
    input logic [RX_IDX_W-1:0] idx
  );
    return {grp, idx};
  endfunction

  // one guard byte: rx flags in the high nibble, tx flags in the low one
  function automatic logic [DATA_W-1:0] guard_byte(
    input logic [NUM_GROUPS-1:0] tx_f,
    input logic [NUM_GROUPS-1:0] rx_f,
    input logic [1:0]            bank
  );
    logic [DATA_W-1:0] v;
    v = GUARD_RESET;
    v[TX_FIELD_LSB +: GRP_PER_BANK] = tx_f[{bank, 2'b00} +: GRP_PER_BANK];
    v[RX_FIELD_LSB +: GRP_PER_BANK] = rx_f[{bank, 2'b00} +: GRP_PER_BANK];
    return v;
  endfunction

  function automatic logic [DEC_W-1:0] decode(
    input logic [ADDR_W-1:0] a
  );
    logic              is_guard;
    logic              is_tx;
    logic              is_rx;
    logic [GRP_W-1:0]  grp;
    logic [TX_IDX_W-1:0] idx;
    logic [ADDR_W-1:0] off;
    is_guard = 1'b0;
    is_tx    = 1'b0;
    is_rx    = 1'b0;
    grp      = '0;
    idx      = '0;
    off      = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (a == GUARD_OFF[b]) begin
        is_guard = 1'b1;
        grp      = GRP_W'(b * GRP_PER_BANK);
      end
      if (in_span(a, TX_BASE[b], TX_SPAN)) begin
        off   = a - TX_BASE[b];
        is_tx = 1'b1;
        grp   = GRP_W'(b * GRP_PER_BANK) + GRP_W'(off[4:3]);
        idx   = off[2:0];
      end
      if (in_span(a, RX_BASE[b], RX_SPAN)) begin
        off   = a - RX_BASE[b];
        is_rx = 1'b1;
        grp   = GRP_W'(b * GRP_PER_BANK) + GRP_W'(off[3:2]);
        idx   = {1'b0, off[1:0]};
      end
    end
    return {is_guard, is_tx, is_rx, grp, idx};
  endfunction

  logic [DEC_W-1:0]    dec;
  logic                hit_guard;
  logic                hit_tx;
  logic                hit_rx;
  logic [GRP_W-1:0]    hit_grp;
  logic [TX_IDX_W-1:0] hit_idx;
  logic                grp_impl;
  logic [1:0]          hit_bank;

  always_comb begin
    dec       = decode(reg_addr);
    hit_guard = dec[DEC_W-1];
    hit_tx    = dec[DEC_W-2];
    hit_rx    = dec[DEC_W-3];
    hit_grp   = dec[TX_IDX_W +: GRP_W];
    hit_idx   = dec[TX_IDX_W-1:0];
    hit_bank  = hit_grp[3:2];
    // tables of absent groups neither store nor read back
    grp_impl  = (32'(hit_grp) < NUM_IMPL);
  end

  // guard register writes fan out to the eight flags of one bank
  logic [NUM_GROUPS-1:0] tx_flag_we;
  logic [NUM_GROUPS-1:0] rx_flag_we;
  logic [NUM_GROUPS-1:0] tx_flag_wd;
  logic [NUM_GROUPS-1:0] rx_flag_wd;
  logic                  tx_elem_we;
  logic                  rx_elem_we;

  always_comb begin
    tx_flag_we = '0;
    rx_flag_we = '0;
    tx_flag_wd = '0;
    rx_flag_wd = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (reg_wr && hit_guard && (hit_bank == 2'(g / GRP_PER_BANK))) begin
        tx_flag_we[g] = 1'b1;
        rx_flag_we[g] = 1'b1;
        tx_flag_wd[g] = reg_wdata[TX_FIELD_LSB + g % GRP_PER_BANK];
        rx_flag_wd[g] = reg_wdata[RX_FIELD_LSB + g % GRP_PER_BANK];
      end
    end
    // table writes only land while the group's flag is set
    tx_elem_we = reg_wr && hit_tx && grp_impl && tx_updating[hit_grp];
    rx_elem_we = reg_wr && hit_rx && grp_impl && rx_updating[hit_grp];
  end

  gtug_guard_bank #(
    .NGRP  (NUM_GROUPS),
    .NIMPL (NUM_IMPL),
    .ELEMS (TX_ELEMS),
    .IDX_W (TX_IDX_W)
  ) u_tx_bank (
    .mclk     (mclk),
    .nrst     (nrst),
    .flag_we  (tx_flag_we),
    .flag_wd  (tx_flag_wd),
    .elem_we  (tx_elem_we),
    .elem_grp (hit_grp),
    .elem_idx (hit_idx),
    .flag     (tx_updating),
    .commit   (tx_commit)
  );

  gtug_guard_bank #(
    .NGRP  (NUM_GROUPS),
    .NIMPL (NUM_IMPL),
    .ELEMS (RX_ELEMS),
    .IDX_W (RX_IDX_W)
  ) u_rx_bank (
    .mclk     (mclk),
    .nrst     (nrst),
    .flag_we  (rx_flag_we),
    .flag_wd  (rx_flag_wd),
    .elem_we  (rx_elem_we),
    .elem_grp (hit_grp),
    .elem_idx (hit_idx[RX_IDX_W-1:0]),
    .flag     (rx_updating),
    .commit   (rx_commit)
  );

  // staging copy takes software writes; active copy feeds the engine
  // a 0 written over a set flag abandons the update: partial bytes stay
  // staged and the active copy is left as it was
  logic [DATA_W-1:0] tx_stage      [TX_DEPTH];
  logic [DATA_W-1:0] tx_act        [TX_DEPTH];
  logic [DATA_W-1:0] rx_stage      [RX_DEPTH];
  logic [DATA_W-1:0] rx_act        [RX_DEPTH];
  logic [DATA_W-1:0] next_tx_stage [TX_DEPTH];
  logic [DATA_W-1:0] next_tx_act   [TX_DEPTH];
  logic [DATA_W-1:0] next_rx_stage [RX_DEPTH];
  logic [DATA_W-1:0] next_rx_act   [RX_DEPTH];

  always_comb begin
    next_tx_stage = tx_stage;
    next_tx_act   = tx_act;
    if (tx_elem_we) begin
      next_tx_stage[tx_slot(hit_grp, hit_idx)] = reg_wdata;
    end
    // commit arrives in the same cycle that the last byte reaches staging
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (tx_commit[g]) begin
        for (int e = 0; e < TX_ELEMS; e++) begin
          next_tx_act[g * TX_ELEMS + e] = tx_stage[g * TX_ELEMS + e];
        end
      end
    end
  end

  always_comb begin
    next_rx_stage = rx_stage;
    next_rx_act   = rx_act;
    if (rx_elem_we) begin
      next_rx_stage[rx_slot(hit_grp, hit_idx[RX_IDX_W-1:0])] = reg_wdata;
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (rx_commit[g]) begin
        for (int e = 0; e < RX_ELEMS; e++) begin
          next_rx_act[g * RX_ELEMS + e] = rx_stage[g * RX_ELEMS + e];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < TX_DEPTH; i++) begin
        tx_stage[i] <= TABLE_RESET;
        tx_act[i]   <= TABLE_RESET;
      end
      for (int i = 0; i < RX_DEPTH; i++) begin
        rx_stage[i] <= TABLE_RESET;
        rx_act[i]   <= TABLE_RESET;
      end
    end else begin
      tx_stage <= next_tx_stage;
      tx_act   <= next_tx_act;
      rx_stage <= next_rx_stage;
      rx_act   <= next_rx_act;
    end
  end

  // register reads and engine lookups, both answered one cycle later
  logic [DATA_W-1:0] next_reg_rdata;
  logic [DATA_W-1:0] next_eng_tx_data;
  logic [DATA_W-1:0] next_eng_rx_data;

  always_comb begin
    next_reg_rdata = READ_IDLE;
    if (reg_rd) begin
      if (hit_guard) begin
        next_reg_rdata = guard_byte(tx_updating, rx_updating,
                                    hit_bank);
      end else if (hit_tx && grp_impl) begin
        next_reg_rdata = tx_stage[tx_slot(hit_grp, hit_idx)];
      end else if (hit_rx && grp_impl) begin
        next_reg_rdata = rx_stage[rx_slot(hit_grp, hit_idx[RX_IDX_W-1:0])];
      end
    end
    // the engine never sees a half-written table
    next_eng_tx_data = tx_act[tx_slot(eng_tx_grp, eng_tx_idx)];
    next_eng_rx_data = rx_act[rx_slot(eng_rx_grp, eng_rx_idx)];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata   <= READ_IDLE;
      eng_tx_data <= TABLE_RESET;
      eng_rx_data <= TABLE_RESET;
    end else begin
      reg_rdata   <= next_reg_rdata;
      eng_tx_data <= next_eng_tx_data;
      eng_rx_data <= next_eng_rx_data;
    end
  end

endmodule

`default_nettype wire

// File: logic/gtug_guard_bank.sv
`timescale 1ns/1ps
`default_nettype none

module gtug_guard_bank
  import gtug_pkg::*;
#(
  parameter int NGRP  = 16,
  parameter int NIMPL = 16,
  parameter int ELEMS = 8,
  parameter int IDX_W = 3
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [NGRP-1:0]  flag_we,
  input  wire logic [NGRP-1:0]  flag_wd,
  input  wire logic             elem_we,
  input  wire logic [GRP_W-1:0] elem_grp,
  input  wire logic [IDX_W-1:0] elem_idx,
  output logic      [NGRP-1:0]  flag,
  output logic      [NGRP-1:0]  commit
);

  logic [ELEMS-1:0] seen      [NGRP];
  logic [ELEMS-1:0] next_seen [NGRP];
  logic [NGRP-1:0]  next_flag;
  logic [NGRP-1:0]  next_commit;

  always_comb begin
    logic [ELEMS-1:0] upd;
    upd         = '0;
    next_flag   = flag;
    next_seen   = seen;
    next_commit = '0;
    for (int g = 0; g < NGRP; g++) begin
      if (g >= NIMPL) begin
        // absent groups keep a flag that never sets
        next_flag[g] = 1'b0;
        next_seen[g] = '0;
      end else if (flag_we[g] && (flag_wd[g] != flag[g])) begin
        // a 1 over a 1 keeps progress; a 0 over a 1 aborts
        next_flag[g] = flag_wd[g];
        next_seen[g] = '0;
      end else if (elem_we && flag[g] && (elem_grp == GRP_W'(g))) begin
        upd = seen[g] | (ELEMS'(1) << elem_idx);
        if (&upd) begin
          next_flag[g]   = 1'b0;
          next_seen[g]   = '0;
          next_commit[g] = 1'b1;
        end else begin
          next_seen[g] = upd;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flag   <= '0;
      commit <= '0;
      for (int g = 0; g < NGRP; g++) begin
        seen[g] <= '0;
      end
    end else begin
      flag   <= next_flag;
      commit <= next_commit;
      seen   <= next_seen;
    end
  end

endmodule

`default_nettype wire

// File: testbench/gtug_group_table_guard_test.sv
`timescale 1ns/1ps
`default_nettype none

module gtug_group_table_guard_test
  import gtug_pkg::*;
;
  logic                  mclk, nrst, reg_wr, reg_rd, roam;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata, reg_rdata, rdata_s, got, got_s, m;
  logic [DATA_W-1:0]     eng_tx_data, eng_rx_data;
  logic [GRP_W-1:0]      eng_tx_grp, eng_rx_grp;
  logic [2:0]            eng_tx_idx;
  logic [1:0]            eng_rx_idx;
  logic [NUM_GROUPS-1:0] tx_updating, rx_updating, tx_commit, rx_commit;
  logic [DATA_W-1:0]     stage [2][16][8];
  logic [DATA_W-1:0]     act [2][16][8];
  int                    failures, check_count, commits, seed, c_base;

  gtug_group_table_guard gtug_group_table_guard_i (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .eng_tx_grp, .eng_tx_idx, .eng_tx_data, .eng_rx_grp, .eng_rx_idx,
    .eng_rx_data, .tx_updating, .rx_updating, .tx_commit, .rx_commit);
  gtug_group_table_guard #(.NUM_IMPL(IMPL_SMALL)) small_gtug_group_table_guard_i (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata_s), .eng_tx_grp, .eng_tx_idx, .eng_tx_data(),
    .eng_rx_grp, .eng_rx_idx, .eng_rx_data(), .tx_updating(),
    .rx_updating(), .tx_commit(), .rx_commit());

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // counted on the falling edge so the tasks never race the tally
  always @(negedge mclk) commits += $countones(tx_commit | rx_commit);

  task automatic cyc(input logic w, r, input logic [11:0] a,
                     input logic [7:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    if (roam && ($random(seed) & 3) == 0) begin
      eng_tx_idx <= 3'($random(seed));
      eng_rx_idx <= 2'($random(seed));
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask

  // sampled at the wake-up of the second edge, before its updates land
  task automatic rd(input logic [11:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    got   = reg_rdata;
    got_s = rdata_s;
  endtask

  task automatic look(input int s, g, i);
    roam = 1'b0;
    if (s == 0) begin
      eng_tx_grp <= 4'(g);
      eng_tx_idx <= 3'(i);
    end else begin
      eng_rx_grp <= 4'(g);
      eng_rx_idx <= 2'(i);
    end
    cyc(1'b0, 1'b0, 12'h000, 8'h00);
    cyc(1'b0, 1'b0, 12'h000, 8'h00);
    got  = s ? eng_rx_data : eng_tx_data;
    roam = 1'b1;
  endtask

  task automatic chk(input logic [7:0] g, e, input string t);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, t, g, e);
    end
  endtask

  task automatic upd(input int s, g);
    int          q, n, c0;
    logic [11:0] base, ga;
    logic [7:0]  v, bit_m;
    q     = g % 4;
    n     = s ? RX_ELEMS : TX_ELEMS;
    ga    = GUARD_OFF[g / 4];
    base  = s ? RX_BASE[g / 4] + 12'(4 * q) : TX_BASE[g / 4] + 12'(8 * q);
    bit_m = 8'(1 << (q + 4 * s));
    wr(base, 8'h5a);
    rd(base);
    chk(got, stage[s][g][0], "drop");
    c0 = commits;
    wr(ga, bit_m);
    wr(base + 12'(n - 1), 8'hee); // repeats must not count twice
    for (int i = n - 1; i >= 0; i--) begin
      v = 8'($random(seed));
      wr(base + 12'(i), v);
      stage[s][g][i] = v;
      if (i == 1) begin
        rd(ga);
        chk(got, bit_m, "busy");
        look(s, g, 0);
        chk(got, act[s][g][0], "old");
      end
    end
    rd(ga);
    chk(got, GUARD_RESET, "done");
    chk(8'(commits - c0), 8'h01, "commit");
    for (int i = 0; i < n; i++) begin
      act[s][g][i] = stage[s][g][i];
      look(s, g, i);
      chk(got, act[s][g][i], "new");
    end
    $display("update side %0d group %0d done", s, g + 1);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end

  initial begin
    seed = 32'hb607;
    {failures, check_count, commits} = '0;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {eng_tx_grp, eng_tx_idx, eng_rx_grp, eng_rx_idx} = '0;
    roam  = 1'b1;
    stage = '{default: TABLE_RESET};
    act   = '{default: TABLE_RESET};
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int b = 0; b < NUM_BANKS; b++) begin
      rd(GUARD_OFF[b]);
      chk(got, GUARD_RESET, "reset");
    end
    rd(12'h41e);
    chk(got, READ_IDLE, "unmapped");
    for (int b = 0; b < NUM_BANKS; b++) begin
      m = 8'($random(seed));
      wr(GUARD_OFF[b], m);
      rd(GUARD_OFF[b]);
      chk(got, m, "flags");
      chk(got_s, b == 0 ? m & 8'h33 : 8'h00, "small");
      wr(GUARD_OFF[b], 8'h00);
    end
    $display("guard register test done");
    // a 1 over a set flag keeps progress, so one more byte completes
    c_base = commits;
    wr(GUARD_OFF[0], 8'h02);
    for (int i = 0; i < 7; i++) begin
      wr(TX_BASE[0] + 12'(8 + i), 8'(8'h30 + i));
      stage[0][1][i] = 8'(8'h30 + i);
    end
    wr(GUARD_OFF[0], 8'h02);
    wr(TX_BASE[0] + 12'h00f, 8'h3f);
    stage[0][1][7] = 8'h3f;
    rd(GUARD_OFF[0]);
    chk(got, GUARD_RESET, "keep");
    chk(8'(commits - c_base), 8'h01, "keep commit");
    act[0][1] = stage[0][1];
    // a 0 over a set flag abandons: no commit, engine keeps old table
    wr(GUARD_OFF[0], 8'h02);
    wr(TX_BASE[0] + 12'h008, 8'hc3);
    stage[0][1][0] = 8'hc3;
    wr(GUARD_OFF[0], 8'h00);
    rd(GUARD_OFF[0]);
    chk(got, GUARD_RESET, "abort");
    rd(TX_BASE[0] + 12'h008);
    chk(got, 8'hc3, "partial");
    look(0, 1, 0);
    chk(got, act[0][1][0], "kept old");
    chk(8'(commits - c_base), 8'h01, "no commit");
    $display("keep and abort test done");
    upd(0, 0);
    upd(1, 0);
    upd(1, 8);
    upd(0, 15);
    upd(0, 0);
    repeat (4) upd($random(seed) & 1, $random(seed) & 15);
    results();
  end
endmodule

`default_nettype wire

// File: testbench/gtug_properties.sv
`timescale 1ns/1ps
`default_nettype none

module gtug_properties
  import gtug_pkg::*;
#(
  parameter int NUM_IMPL = IMPL_LARGE
) (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [DATA_W-1:0]     reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [DATA_W-1:0]     reg_rdata,
  input wire logic [GRP_W-1:0]      eng_tx_grp,
  input wire logic [2:0]            eng_tx_idx,
  input wire logic [DATA_W-1:0]     eng_tx_data,
  input wire logic [NUM_GROUPS-1:0] tx_updating,
  input wire logic [NUM_GROUPS-1:0] rx_updating,
  input wire logic [NUM_GROUPS-1:0] tx_commit,
  input wire logic [NUM_GROUPS-1:0] rx_commit
);
  // absent groups never show a flag, so expectations are masked
  localparam logic [15:0] IMPL_M = 16'((32'd1 << NUM_IMPL) - 1);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  flag_read_a: assert property (
    reg_rd && reg_addr == 12'h41f |=> reg_rdata ==
      {$past(rx_updating[3:0]), $past(tx_updating[3:0])})
    else $error("guard read mismatch");
  flag_write_a: assert property (
    reg_wr && reg_addr == 12'h51f |=> {rx_updating[7:4], tx_updating[7:4]}
      == ($past(reg_wdata) & {IMPL_M[7:4], IMPL_M[7:4]}))
    else $error("guard write mismatch");
  commit_clear_a: assert property (
    tx_commit[0] |-> !tx_updating[0] && $past(tx_updating[0]))
    else $error("commit without flag clear");
  tx_commit_src_a: assert property (
    tx_commit[0] |-> $past(reg_wr && reg_addr[11:3] == 9'h084))
    else $error("tx commit without table write");
  rx_commit_src_a: assert property (
    rx_commit[8] |-> $past(reg_wr && reg_addr[11:2] == 10'h1b4))
    else $error("rx commit without table write");
  fall_cause_a: assert property (
    $fell(rx_updating[0]) |->
      rx_commit[0] || $past(reg_wr && reg_addr == 12'h41f))
    else $error("flag cleared without cause");
  old_table_a: assert property (
    tx_updating[0] && eng_tx_grp == 4'h0 && $stable(eng_tx_grp)
      && $stable(eng_tx_idx) |=> $stable(eng_tx_data))
    else $error("active table changed during update");

  cover property (tx_commit[0]);
  cover property (rx_commit[8]);
  cover property (reg_rd && reg_addr == 12'h41f);
endmodule

bind gtug_group_table_guard gtug_properties #(.NUM_IMPL(NUM_IMPL))
  gtug_properties_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .eng_tx_grp, .eng_tx_idx, .eng_tx_data, .tx_updating,
  .rx_updating, .tx_commit, .rx_commit);

`default_nettype wire
